// ### dslc_pkg.sv
// package: constants and types for the drive security lock control block
package dslc_pkg;
  localparam logic [7:0] OP_SET_PW = 8'hf1;
  localparam logic [7:0] OP_UNLOCK = 8'hf2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
  localparam logic [7:0] OP_FREEZE = 8'hf5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hf6;
  localparam logic [15:0] REV_DEFAULT = 16'hfffe;
  localparam logic [15:0] REV_MIN = 16'h0001;
  localparam logic [15:0] REV_MAX = 16'hfffe;
  localparam logic [2:0] ATTEMPT_LIMIT = 3'h5;
  localparam int LIMIT_FLAG_BIT = 4;
  localparam int PW_W = 32;
  // register offsets
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_REV = 4'h1;
  localparam logic [3:0] A_IRQ_STAT = 4'h2;
  localparam logic [3:0] A_IRQ_MASK = 4'h3;
  localparam logic [3:0] A_WORD128 = 4'h4;
  // status bit positions
  localparam int ST_LOCKED = 0;
  localparam int ST_FROZEN = 1;
  localparam int ST_ENABLED = 2;
  localparam int ST_MAXLVL = 3;
  localparam int ST_PREP = 4;
  // interrupt bits: 0 done, 1 aborted, 2 erase, 3 mismatch
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {DSLC_UNLOCKED, DSLC_LOCKED, DSLC_FROZEN} dslc_mode_t;
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic use_master;
    logic max_level;
    logic [31:0] password;
    logic [15:0] rev;
  } dslc_cmd_t;
  typedef struct packed {
    logic done;
    logic aborted;
    logic erase_all;
  } dslc_resp_t;
endpackage : dslc_pkg

// ### dslc_attempts.sv
// password mismatch counter with attempt limit flag
module dslc_attempts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic miss_i,
  output logic limit_o
);
  typedef struct packed {
    logic [2:0] cnt;
  } dslc_att_t;
  dslc_att_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    if (miss_i && s_reg.cnt != dslc_pkg::ATTEMPT_LIMIT) begin
      s_next.cnt = s_reg.cnt + 3'h1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign limit_o = (s_reg.cnt == dslc_pkg::ATTEMPT_LIMIT);
  property p_limit;
    @(posedge clk_i) disable iff (rst_i) limit_o |=> limit_o;
  endproperty
  a_limit: assert property (p_limit) else $error("limit flag dropped");
endmodule : dslc_attempts

// ### dslc_pw_match.sv
// password compare unit
module dslc_pw_match #(
  parameter int W = 32
) (
  input wire logic [W-1:0] given_i,
  input wire logic [W-1:0] user_i,
  input wire logic [W-1:0] master_i,
  input wire logic use_master_i,
  output logic match_o
);
  assign match_o = use_master_i ? (given_i == master_i) : (given_i == user_i);
endmodule : dslc_pw_match

// ### dslc_core.sv
// drive security lock control: mode tracking, passwords and command gating
//
// Contract
// - six security opcodes f1 to f6 recognised
// - lock enabled means locked after power-on
// - no user password means unlocked after reset
// - freeze lock enters frozen, blocks password changes
// - frozen holds until power removed; here any rst_i pulse clears it too
// - high level: master password unlocks too
// - max level: master only via erase unit
// - master password never enables lock
// - report master revision code, word 92
// - revision code defaults to fffe
// - user password enables lock next reset
// - media access refused until unlock succeeds
// - five mismatches set limit flag, abort
// - per-mode abort table for security commands
module dslc_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dslc_pkg::dslc_cmd_t cmd_i,
  input wire logic media_cmd_i,
  output dslc_pkg::dslc_resp_t resp_o,
  output logic media_allow_o,
  output logic [15:0] word92_o,
  output logic [15:0] word128_o,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  localparam int PW = dslc_pkg::PW_W;
  ////////////////////////////////////////////////////////////////////////////
  // persistent storage: survives reset as nonvolatile media would
  typedef struct packed {
    logic [PW-1:0] user_pw;
    logic [PW-1:0] master_pw;
    logic enabled;
    logic max_level;
    logic [15:0] rev;
    logic init;
  } dslc_nv_t;
  // volatile state
  typedef struct packed {
    dslc_pkg::dslc_mode_t mode;
    logic prep;
    logic booted;
    logic [dslc_pkg::IRQ_W-1:0] irq_stat;
    logic [dslc_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    dslc_pkg::dslc_resp_t resp;
  } dslc_st_t;
  dslc_nv_t nv_reg, nv_next;
  dslc_st_t s_reg, s_next;
  logic match;
  logic limit;
  logic miss;
  logic [dslc_pkg::IRQ_W-1:0] ev;
  dslc_pw_match #(.W(PW)) u_match (
    .given_i(cmd_i.password),
    .user_i(nv_reg.user_pw),
    .master_i(nv_reg.master_pw),
    .use_master_i(cmd_i.use_master),
    .match_o(match)
  );
  dslc_attempts u_att (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .miss_i(miss),
    .limit_o(limit)
  );
  function automatic logic is_sec(input logic [7:0] op);
    is_sec = (op >= dslc_pkg::OP_SET_PW) && (op <= dslc_pkg::OP_DISABLE_PW);
  endfunction : is_sec
  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile store: loads shipped defaults once
  always_ff @(posedge clk_i) begin
    nv_reg <= nv_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  // command interpreter
  always_comb begin
    nv_next = nv_reg;
    s_next = s_reg;
    miss = 1'b0;
    ev = '0;
    s_next.resp = '0;
    // an unknown flag at power-up falls into the else branch and loads defaults
    if (nv_reg.init) begin
      nv_next = nv_reg;
    end else begin
      nv_next = '0;
      nv_next.init = 1'b1;
      nv_next.rev = dslc_pkg::REV_DEFAULT;
    end
    if (!s_reg.booted) begin
      s_next.booted = 1'b1;
      s_next.mode = (nv_reg.init && nv_reg.enabled) ? dslc_pkg::DSLC_LOCKED :
                    dslc_pkg::DSLC_UNLOCKED;
    end else if (cmd_i.valid && is_sec(cmd_i.opcode)) begin
      s_next.resp.done = 1'b1;
      s_next.prep = 1'b0;
      case (cmd_i.opcode)
        dslc_pkg::OP_SET_PW: begin
          if (s_reg.mode != dslc_pkg::DSLC_UNLOCKED) begin
            s_next.resp.aborted = 1'b1;
          end else if (cmd_i.use_master) begin
            nv_next.master_pw = cmd_i.password;
            if (cmd_i.rev >= dslc_pkg::REV_MIN && cmd_i.rev <= dslc_pkg::REV_MAX) begin
              nv_next.rev = cmd_i.rev;
            end
          end else begin
            nv_next.user_pw = cmd_i.password;
            nv_next.enabled = 1'b1;
            nv_next.max_level = cmd_i.max_level;
          end
        end
        dslc_pkg::OP_UNLOCK: begin
          if (s_reg.mode == dslc_pkg::DSLC_FROZEN || limit) begin
            s_next.resp.aborted = 1'b1;
          end else if (cmd_i.use_master && nv_reg.max_level) begin
            s_next.resp.aborted = 1'b1;
          end else if (match) begin
            if (s_reg.mode == dslc_pkg::DSLC_LOCKED) begin
              s_next.mode = dslc_pkg::DSLC_UNLOCKED;
            end
          end else begin
            miss = 1'b1;
            s_next.resp.aborted = 1'b1;
          end
        end
        dslc_pkg::OP_ERASE_PREP: begin
          if (s_reg.mode == dslc_pkg::DSLC_FROZEN) begin
            s_next.resp.aborted = 1'b1;
          end else begin
            s_next.prep = 1'b1;
          end
        end
        dslc_pkg::OP_ERASE_UNIT: begin
          if (s_reg.mode == dslc_pkg::DSLC_FROZEN || limit || !s_reg.prep) begin
            s_next.resp.aborted = 1'b1;
          end else if (match) begin
            s_next.resp.erase_all = 1'b1;
            s_next.mode = dslc_pkg::DSLC_UNLOCKED;
            nv_next.enabled = 1'b0;
            nv_next.user_pw = '0;
          end else begin
            miss = 1'b1;
            s_next.resp.aborted = 1'b1;
          end
        end
        dslc_pkg::OP_FREEZE: begin
          if (s_reg.mode == dslc_pkg::DSLC_LOCKED) begin
            s_next.resp.aborted = 1'b1;
          end else begin
            s_next.mode = dslc_pkg::DSLC_FROZEN;
          end
        end
        dslc_pkg::OP_DISABLE_PW: begin
          if (s_reg.mode != dslc_pkg::DSLC_UNLOCKED) begin
            s_next.resp.aborted = 1'b1;
          end else if (match) begin
            nv_next.enabled = 1'b0;
            nv_next.user_pw = '0;
          end else begin
            miss = 1'b1;
            s_next.resp.aborted = 1'b1;
          end
        end
        default: begin
          s_next.resp.done = 1'b0;
        end
      endcase
    end else if (cmd_i.valid) begin
      s_next.prep = 1'b0;
    end
    ev[0] = s_next.resp.done;
    ev[1] = s_next.resp.aborted;
    ev[2] = s_next.resp.erase_all;
    ev[3] = miss;
    // register bus: read clears irq status, new events win
    s_next.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        dslc_pkg::A_STATUS: begin
          s_next.rdata = {27'h0, s_reg.prep, nv_reg.max_level, nv_reg.enabled,
                          s_reg.mode == dslc_pkg::DSLC_FROZEN,
                          s_reg.mode == dslc_pkg::DSLC_LOCKED};
        end
        dslc_pkg::A_REV: s_next.rdata = {16'h0, nv_reg.rev};
        dslc_pkg::A_IRQ_STAT: begin
          s_next.rdata = {28'h0, s_reg.irq_stat};
          s_next.irq_stat = '0;
        end
        dslc_pkg::A_IRQ_MASK: s_next.rdata = {28'h0, s_reg.irq_mask};
        dslc_pkg::A_WORD128: s_next.rdata = {16'h0, word128_o};
        default: s_next.rdata = '0;
      endcase
    end
    if (wr_i && addr_i == dslc_pkg::A_IRQ_MASK) begin
      s_next.irq_mask = wdata_i[dslc_pkg::IRQ_W-1:0];
    end
    s_next.irq_stat = s_next.irq_stat | ev;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign resp_o = s_reg.resp;
  assign media_allow_o = s_reg.booted && s_reg.mode != dslc_pkg::DSLC_LOCKED;
  assign word92_o = nv_reg.init ? nv_reg.rev : dslc_pkg::REV_DEFAULT;
  always_comb begin
    word128_o = '0;
    word128_o[dslc_pkg::LIMIT_FLAG_BIT] = limit;
    word128_o[1] = nv_reg.enabled;
    word128_o[2] = s_reg.mode == dslc_pkg::DSLC_LOCKED;
    word128_o[3] = s_reg.mode == dslc_pkg::DSLC_FROZEN;
    word128_o[8] = nv_reg.max_level;
  end
  assign rdata_o = s_reg.rdata;
  assign irq_o = |(s_reg.irq_stat & s_reg.irq_mask);
  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_frozen_sticks;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.mode == dslc_pkg::DSLC_FROZEN |=> s_reg.mode == dslc_pkg::DSLC_FROZEN;
  endproperty
  a_frozen_sticks: assert property (p_frozen_sticks) else $error("left frozen");
  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_FREEZE &&
      s_reg.mode == dslc_pkg::DSLC_UNLOCKED |=> s_reg.mode == dslc_pkg::DSLC_FROZEN;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not taken");
  property p_frozen_abort;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && s_reg.mode == dslc_pkg::DSLC_FROZEN && cmd_i.valid &&
      cmd_i.opcode != dslc_pkg::OP_FREEZE && is_sec(cmd_i.opcode) |=> resp_o.aborted;
  endproperty
  a_frozen_abort: assert property (p_frozen_abort) else $error("frozen not aborted");
  property p_locked_media;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.mode == dslc_pkg::DSLC_LOCKED |-> !media_allow_o;
  endproperty
  a_locked_media: assert property (p_locked_media) else $error("media open locked");
  property p_boot_mode;
    @(posedge clk_i) disable iff (rst_i)
      !rst_i && !s_reg.booted && nv_reg.init |=>
      s_reg.mode == (nv_reg.enabled ? dslc_pkg::DSLC_LOCKED : dslc_pkg::DSLC_UNLOCKED);
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("bad boot mode");
  property p_no_prep;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_ERASE_UNIT &&
      !s_reg.prep |=> resp_o.aborted && !resp_o.erase_all;
  endproperty
  a_no_prep: assert property (p_no_prep) else $error("erase without prepare");
  property p_limit_abort;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && limit && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_UNLOCK
      |=> resp_o.aborted;
  endproperty
  a_limit_abort: assert property (p_limit_abort) else $error("unlock past limit");
  property p_master_max;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_UNLOCK &&
      cmd_i.use_master && nv_reg.max_level && s_reg.mode == dslc_pkg::DSLC_LOCKED
      |=> s_reg.mode == dslc_pkg::DSLC_LOCKED;
  endproperty
  a_master_max: assert property (p_master_max) else $error("master unlocked max");
  property p_master_set;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_SET_PW &&
      cmd_i.use_master |=> nv_reg.enabled == $past(nv_reg.enabled);
  endproperty
  a_master_set: assert property (p_master_set) else $error("master enabled lock");
  property p_limit_erase;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && limit && cmd_i.valid && cmd_i.opcode == dslc_pkg::OP_ERASE_UNIT
      |=> resp_o.aborted && !resp_o.erase_all;
  endproperty
  a_limit_erase: assert property (p_limit_erase) else $error("erase past limit");
  property p_locked_abort;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && s_reg.mode == dslc_pkg::DSLC_LOCKED && cmd_i.valid &&
      (cmd_i.opcode == dslc_pkg::OP_SET_PW || cmd_i.opcode == dslc_pkg::OP_FREEZE ||
      cmd_i.opcode == dslc_pkg::OP_DISABLE_PW) |=> resp_o.aborted;
  endproperty
  a_locked_abort: assert property (p_locked_abort) else $error("locked not aborted");
  property p_user_set;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && s_reg.mode == dslc_pkg::DSLC_UNLOCKED && cmd_i.valid &&
      cmd_i.opcode == dslc_pkg::OP_SET_PW && !cmd_i.use_master
      |=> nv_reg.enabled && s_reg.mode == dslc_pkg::DSLC_UNLOCKED;
  endproperty
  a_user_set: assert property (p_user_set) else $error("user set wrong");
  property p_open_media;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.booted && media_cmd_i && s_reg.mode != dslc_pkg::DSLC_LOCKED |-> media_allow_o;
  endproperty
  a_open_media: assert property (p_open_media) else $error("media refused open");
endmodule : dslc_core

// ### dslc_host_model.sv
// host side model that issues security commands and samples their answers
module dslc_host_model (
  input wire logic clk_i,
  output dslc_pkg::dslc_cmd_t cmd_o,
  input wire dslc_pkg::dslc_resp_t resp_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic master_done;
  dslc_pkg::dslc_resp_t last_resp;
  initial begin
    cmd_o = '0;
    master_done = 1'b0;
    last_resp = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // valid for one cycle; released fields are inverted so stale values never pass
  task automatic send(input logic [7:0] op, input logic um, input logic ml,
    input logic [31:0] pw, input logic [15:0] rv);
    dslc_pkg::dslc_cmd_t c;
    c = {1'b1, op, um, ml, pw, rv};
    @(posedge clk_i);
    cmd_o <= c;
    @(posedge clk_i);
    cmd_o <= {1'b0, ~c[$bits(c)-2:0]};
    @(negedge clk_i);
    last_resp = resp_i;
    if (op == 8'hf1 && um && last_resp.done && !last_resp.aborted) begin
      master_done = 1'b1;
    end
  endtask : send
  // a user password is never stored before a master password
  task automatic issue(input logic [7:0] op, input logic um, input logic ml,
    input logic [31:0] pw, input logic [15:0] rv);
    if (op == 8'hf1 && !um && !master_done) begin
      send(8'hf1, 1'b1, 1'b0, ~pw, rv);
    end
    send(op, um, ml, pw, rv);
  endtask : issue
endmodule : dslc_host_model

// ### tb_drive_security_lock_control.sv
// testbench for the security lock control core
module tb_drive_security_lock_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] UPW = 32'h5a17c0de;
  localparam logic [31:0] MPW = 32'h0badf00d;
  logic clk_i, rst_i, media_cmd_i, wr_i, rd_i, irq_o, media_allow_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, seed, rd_val;
  logic [15:0] word92_o, word128_o, rev;
  logic [7:0] lk_ops[3];
  logic [7:0] fz_ops[5];
  dslc_pkg::dslc_cmd_t cmd;
  dslc_pkg::dslc_resp_t resp_o;
  int num_errors, check_count, cycles, misses;
  dslc_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .media_cmd_i(media_cmd_i),
    .resp_o(resp_o), .media_allow_o(media_allow_o), .word92_o(word92_o),
    .word128_o(word128_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
  dslc_host_model i_host (.clk_i(clk_i), .cmd_o(cmd), .resp_i(resp_o));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // answer code {done, aborted, erase_all}
  task automatic run(input logic [7:0] op, input logic um, input logic ml,
    input logic [31:0] pw, input logic [15:0] rv, input logic [2:0] exp);
    i_host.issue(op, um, ml, pw, rv);
    chk("resp", {29'h0, exp}, {29'h0, i_host.last_resp});
  endtask : run
  task automatic mode(input logic lim, input logic mx, input logic fr, input logic lk,
    input logic en);
    @(negedge clk_i);
    chk("word128", {16'h0, 7'h0, mx, 3'h0, lim, fr, lk, en, 1'b0},
      {16'h0, word128_o & 16'h011e});
    chk("media_allow", {31'h0, !lk}, {31'h0, media_allow_o});
  endtask : mode
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    rd_val = rdata_o;
  endtask : rd
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    media_cmd_i <= ~media_cmd_i;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    rst_i = 1'b1;
    media_cmd_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    seed = 32'h086ef33a;
    lk_ops = '{8'hf1, 8'hf5, 8'hf6};
    fz_ops = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6};
    do_reset;
    mode(0, 0, 0, 0, 0);
    chk("word92", 32'hfffe, {16'h0, word92_o});
    seed = xs(seed);
    rev = (seed[15:0] == 16'h0 || seed[15:0] == 16'hffff) ? 16'h1234 : seed[15:0];
    run(8'hf1, 1'b1, 1'b0, MPW, rev, 3'b100);
    chk("word92", {16'h0, rev}, {16'h0, word92_o});
    mode(0, 0, 0, 0, 0);
    run(8'hf1, 1'b1, 1'b0, MPW, 16'hffff, 3'b100);
    chk("word92", {16'h0, rev}, {16'h0, word92_o});
    run(8'hec, 1'b0, 1'b0, UPW, 16'h0, 3'b000);
    // interrupt raised, read back, cleared on read, then masked
    wr(4'h3, 32'h0000000f);
    rd(4'h3);
    chk("irq_mask", 32'hf, rd_val & 32'hf);
    rd(4'h2);
    chk("irq", 32'h0, {31'h0, irq_o});
    run(8'hf3, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(4'h0);
    chk("status", 32'h10, rd_val & 32'h1f);
    rd(4'h2);
    chk("irq_stat", 32'h1, rd_val & 32'hf);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(4'h3, 32'h0);
    run(8'hf3, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(4'h7);
    chk("unmapped", 32'h0, rd_val);
    run(8'hf1, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    mode(0, 0, 0, 0, 1);
    do_reset;
    mode(0, 0, 0, 1, 1);
    foreach (lk_ops[i]) run(lk_ops[i], 1'b0, 1'b0, UPW, 16'h0, 3'b110);
    run(8'hf2, 1'b1, 1'b0, MPW, 16'h0, 3'b100);
    mode(0, 0, 0, 0, 1);
    run(8'hf5, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    mode(0, 0, 1, 0, 1);
    foreach (fz_ops[i]) run(fz_ops[i], 1'b0, 1'b0, UPW, 16'h0, 3'b110);
    mode(0, 0, 1, 0, 1);
    do_reset;
    mode(0, 0, 0, 1, 1);
    run(8'hf4, 1'b1, 1'b0, MPW, 16'h0, 3'b110);
    run(8'hf3, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    run(8'hf4, 1'b1, 1'b0, MPW, 16'h0, 3'b101);
    mode(0, 0, 0, 0, 0);
    run(8'hf1, 1'b0, 1'b1, UPW, 16'h0, 3'b100);
    do_reset;
    mode(0, 1, 0, 1, 1);
    run(8'hf2, 1'b1, 1'b0, MPW, 16'h0, 3'b110);
    do_reset;
    misses = 0;
    while (misses < 5) begin
      seed = xs(seed);
      // a master attempt at the maximum level is refused before any compare
      run(8'hf2, seed[0], 1'b0, (seed == UPW) ? ~seed : seed, 16'h0, 3'b110);
      if (!seed[0]) begin
        misses++;
      end
      mode(misses == 5, 1, 0, 1, 1);
    end
    run(8'hf2, 1'b0, 1'b0, UPW, 16'h0, 3'b110);
    run(8'hf3, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    run(8'hf4, 1'b1, 1'b0, MPW, 16'h0, 3'b110);
    do_reset;
    mode(0, 1, 0, 1, 1);
    run(8'hf2, 1'b0, 1'b0, UPW, 16'h0, 3'b100);
    mode(0, 1, 0, 0, 1);
    results();
  end
endmodule : tb_drive_security_lock_control
